// [rtl/cis_defs.svh]
// Register offsets, field layout, reset values for the interrupt selector
`ifndef CIS_DEFS_SVH
`define CIS_DEFS_SVH

`define CIS_ADDR_W 32
`define CIS_OFF_SEL_HIGH 32'h019C_0000
`define CIS_OFF_SEL_LOW 32'h019C_0004
`define CIS_OFF_POLARITY 32'h019C_0008
`define CIS_OFF_IRQ_STATUS 32'h019C_0010
`define CIS_OFF_IRQ_MASK 32'h019C_0014
`define CIS_SEL_W 5
`define CIS_NUM_SRC 32
`define CIS_NUM_LINES 16
`define CIS_SEL_USED_MASK 32'h7FFF_7FFF
`define CIS_SEL_LOW_RST 32'h2507_18A4
`define CIS_SEL_HIGH_RST 32'h0820_2D43
`define CIS_POL_MASK 32'h0000_000F
`define CIS_POL_RST 32'h0000_0000
`define CIS_READ_ZERO 32'h0000_0000

`endif

// [rtl/cis_pkg.sv]
// Types shared by the interrupt selector files
package cis_pkg;
    typedef logic [4:0] cis_sel_t;
    typedef logic [31:0] cis_word_t;
endpackage

// [rtl/cis_sync.sv]
// Two-stage synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module cis_sync #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule

// [rtl/cis_route.sv]
// One maskable line: picks its source from the 32-entry event vector
`timescale 1ns/1ps
module cis_route
    import cis_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Selection
    input wire cis_sel_t sel_i,
    input wire logic [31:0] src_i,
    output logic line_o
);
    logic line_r;
    logic line_nxt;

    assign line_nxt = src_i[sel_i];

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            line_r <= 1'b0;
        end else begin
            line_r <= line_nxt;
        end
    end

    assign line_o = line_r;
endmodule

// [rtl/cis_top.sv]
// Interrupt selector: routes event sources onto sixteen core lines
`timescale 1ns/1ps
`include "cis_defs.svh"
module cis_top
    import cis_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // Register port
    input wire logic [31:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    // Fixed sources
    input wire logic nmi_i,
    // Pin sources (asynchronous)
    input wire logic [3:0] external_pin_irq_i,
    // On-chip sources (core clock)
    input wire logic host_irq_i,
    input wire logic timer_zero_irq_i,
    input wire logic timer_one_irq_i,
    input wire logic refresh_timer_irq_i,
    input wire logic [3:0] gp_pin_irq_i,
    input wire logic dma_done_irq_i,
    input wire logic emulation_dma_event_i,
    input wire logic emulation_rx_event_i,
    input wire logic emulation_tx_event_i,
    input wire logic serial0_tx_irq_i,
    input wire logic serial0_rx_irq_i,
    input wire logic serial1_tx_irq_i,
    input wire logic serial1_rx_irq_i,
    input wire logic gp_pin_zero_irq_i,
    input wire logic timer_two_irq_i,
    input wire logic twowire_irq_i,
    input wire logic network_mgmt_irq_i,
    input wire logic video_port_a_irq_i,
    input wire logic video_port_b_irq_i,
    input wire logic video_port_c_irq_i,
    input wire logic audio_tx_irq_i,
    input wire logic audio_rx_irq_i,
    // Core interrupt lines and summary interrupt
    output logic [15:0] core_irq_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Register state

    cis_word_t sel_high_r;
    cis_word_t sel_low_r;
    cis_word_t pol_r;
    cis_word_t status_r;
    cis_word_t mask_r;
    cis_word_t rdata_r;
    logic nmi_r;
    logic [11:0] prev_lines_r;

    wire hit_high = addr_i == `CIS_OFF_SEL_HIGH;
    wire hit_low = addr_i == `CIS_OFF_SEL_LOW;
    wire hit_pol = addr_i == `CIS_OFF_POLARITY;
    wire hit_stat = addr_i == `CIS_OFF_IRQ_STATUS;
    wire hit_mask = addr_i == `CIS_OFF_IRQ_MASK;

    wire cis_word_t wr_sel = wdata_i & `CIS_SEL_USED_MASK;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sel_high_r <= `CIS_SEL_HIGH_RST;
            sel_low_r <= `CIS_SEL_LOW_RST;
            pol_r <= `CIS_POL_RST;
            mask_r <= `CIS_READ_ZERO;
        end else if (wr_i) begin
            if (hit_high) begin
                sel_high_r <= wr_sel;
            end
            if (hit_low) begin
                sel_low_r <= wr_sel;
            end
            if (hit_pol) begin
                pol_r <= wdata_i & `CIS_POL_MASK;
            end
            if (hit_mask) begin
                mask_r <= {20'h0_0000, wdata_i[11:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: data the cycle after the strobe

    cis_word_t rd_mux;
    assign rd_mux = hit_high ? sel_high_r :
                    hit_low ? sel_low_r :
                    hit_pol ? pol_r :
                    hit_stat ? status_r :
                    hit_mask ? mask_r : `CIS_READ_ZERO;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_r <= `CIS_READ_ZERO;
        end else begin
            rdata_r <= rd_i ? rd_mux : `CIS_READ_ZERO;
        end
    end
    assign rdata_o = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Source vector indexed by selector code

    logic [3:0] ext_sync;
    logic [3:0] ext_act;
    logic [31:0] src;

    cis_sync #(.W(4)) u_ext_sync (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .async_i(external_pin_irq_i),
        .sync_o(ext_sync)
    );

    // Polarity bit set means the pin is active low
    assign ext_act = ext_sync ^ pol_r[3:0];

    // Pins and their GP inputs share one code each
    assign src[0] = host_irq_i;
    assign src[1] = timer_zero_irq_i;
    assign src[2] = timer_one_irq_i;
    assign src[3] = refresh_timer_irq_i;
    assign src[7:4] = gp_pin_irq_i | ext_act;
    assign src[8] = dma_done_irq_i;
    assign src[9] = emulation_dma_event_i;
    assign src[10] = emulation_rx_event_i;
    assign src[11] = emulation_tx_event_i;
    assign src[12] = serial0_tx_irq_i;
    assign src[13] = serial0_rx_irq_i;
    assign src[14] = serial1_tx_irq_i;
    assign src[15] = serial1_rx_irq_i;
    assign src[16] = gp_pin_zero_irq_i;
    assign src[17] = 1'b0;
    assign src[18] = 1'b0;
    assign src[19] = timer_two_irq_i;
    assign src[20] = 1'b0;
    assign src[21] = 1'b0;
    assign src[22] = twowire_irq_i;
    assign src[23] = 1'b0;
    assign src[24] = network_mgmt_irq_i;
    assign src[25] = video_port_a_irq_i;
    assign src[26] = video_port_b_irq_i;
    assign src[27] = video_port_c_irq_i;
    assign src[28] = audio_tx_irq_i;
    assign src[29] = audio_rx_irq_i;
    // Reserved codes route nothing, so a bad write just silences a line
    assign src[31:30] = 2'b00;

    ////////////////////////////////////////////////////////////////////////
    // Maskable lines 4..15

    function automatic cis_sel_t field_of(input cis_word_t r, input int k);
        cis_sel_t f;
        f = '0;
        case (k)
            0: f = r[4:0];
            1: f = r[9:5];
            2: f = r[14:10];
            3: f = r[20:16];
            4: f = r[25:21];
            default: f = r[30:26];
        endcase
        return f;
    endfunction

    logic [11:0] lines;

    genvar g;
    generate
        for (g = 0; g < 12; g++) begin : g_line
            cis_route u_route (
                .ref_clk_i(ref_clk_i),
                .rst_i(rst_i),
                .sel_i(g < 6 ? field_of(sel_low_r, g) :
                    field_of(sel_high_r, g - 6)),
                .src_i(src),
                .line_o(lines[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Fixed lines and outputs

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nmi_r <= 1'b0;
            prev_lines_r <= 12'h000;
        end else begin
            nmi_r <= nmi_i;
            prev_lines_r <= lines;
        end
    end

    // Line 0 shows reset; 2 and 3 stay quiet
    assign core_irq_o = {lines, 2'b00, nmi_r, rst_i};

    ////////////////////////////////////////////////////////////////////////
    // Sticky status of rising line edges; read clears

    wire [11:0] rise = lines & ~prev_lines_r;
    wire stat_rd = rd_i & hit_stat;

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_r <= `CIS_READ_ZERO;
        end else begin
            // An edge in the clearing cycle survives
            status_r <= {20'h0_0000,
                (stat_rd ? 12'h000 : status_r[11:0]) | rise};
        end
    end

    assign irq_o = |(status_r[11:0] & mask_r[11:0]);

    ////////////////////////////////////////////////////////////////////////
    // Checks

    chk_fixed_lines: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        core_irq_o[3:2] == 2'b00 && core_irq_o[0] == 1'b0)
        else $error("fixed lines wrong");

    chk_sel_apply: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        wr_i && hit_low |=> sel_low_r == $past(wr_sel))
        else $error("low selector not written");

    chk_high_apply: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        wr_i && hit_high |=> sel_high_r == $past(wr_sel))
        else $error("high selector not written");

    chk_unused_zero: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        sel_high_r[15] == 1'b0 && sel_high_r[31] == 1'b0 &&
        sel_low_r[15] == 1'b0 && sel_low_r[31] == 1'b0)
        else $error("unused selector bits set");

    chk_route_line: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        ##1 $stable(sel_low_r) |->
        lines[0] == $past(src[sel_low_r[4:0]]))
        else $error("line 4 does not follow its source");

    chk_route_top: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        ##1 $stable(sel_high_r) |->
        core_irq_o[15] == $past(src[sel_high_r[30:26]]))
        else $error("line 15 does not follow its source");

    // Pin seen two edges late; skipped while the sync stages refill
    chk_polarity: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        !$past(rst_i, 2) |-> src[4] == (gp_pin_irq_i[0] |
        ($past(external_pin_irq_i[0], 2) ^ pol_r[0])))
        else $error("pin polarity not applied");

    chk_nmi_line: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        core_irq_o[1] == $past(nmi_i))
        else $error("nmi line late");

    chk_read_data: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        rd_i && hit_low ##1 !$past(wr_i) |->
        rdata_o == sel_low_r)
        else $error("low selector readback wrong");

    chk_rdata_idle: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        !rd_i |=> rdata_o == `CIS_READ_ZERO)
        else $error("read data not cleared");

    chk_status_hold: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        !stat_rd |=> (status_r[11:0] & $past(status_r[11:0])) ==
        $past(status_r[11:0]))
        else $error("status bit lost without a read");

    // Set wins over the clearing read
    chk_clear_keep: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        stat_rd |=> status_r[11:0] == $past(rise))
        else $error("edge in clearing cycle lost");

    chk_irq_masked: assert property (@(posedge ref_clk_i)
        disable iff (rst_i)
        mask_r[11:0] == 12'h000 |-> !irq_o)
        else $error("interrupt raised while masked");
endmodule

// [test/cis_core_model.sv]
// Core side model: reports the highest priority active interrupt line
`timescale 1ns/1ps
module cis_core_model (
    // Core interrupt lines
    input wire logic [15:0] core_irq_i,
    // Highest priority pending line
    output logic [3:0] top_line_o,
    output logic any_o
);
    // Scan from line 15 down so the lowest set line wins ties
    always_comb begin
        top_line_o = 4'h0;
        for (int k = 15; k >= 0; k--) begin
            if (core_irq_i[k] === 1'b1) begin
                top_line_o = 4'(k);
            end
        end
        any_o = |core_irq_i;
    end
endmodule

// [test/test_cpu_interrupt_selector.sv]
// Testbench for the interrupt selector
`timescale 1ns/1ps
`include "cis_defs.svh"
module test_cpu_interrupt_selector;
    import cis_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [31:0] addr_i = 32'h0000_0000;
    logic [31:0] wdata_i = 32'h0000_0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic nmi_i = 1'b0;
    logic [3:0] ext_r = 4'h0;
    logic [31:0] src = 32'h0000_0000;
    logic [31:0] rdata_o;
    logic [15:0] core_irq_o;
    logic irq_o;
    logic [3:0] top_line;
    logic any_line;
    int error_cnt = 0;
    int compares = 0;
    localparam int DFLT [12] = '{4, 5, 6, 7, 8, 9, 3, 10, 11, 0, 1, 2};

    cis_top u_cis_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .nmi_i(nmi_i), .external_pin_irq_i(ext_r),
        .host_irq_i(src[0]), .timer_zero_irq_i(src[1]),
        .timer_one_irq_i(src[2]), .refresh_timer_irq_i(src[3]),
        .gp_pin_irq_i(src[7:4]), .dma_done_irq_i(src[8]),
        .emulation_dma_event_i(src[9]), .emulation_rx_event_i(src[10]),
        .emulation_tx_event_i(src[11]), .serial0_tx_irq_i(src[12]),
        .serial0_rx_irq_i(src[13]), .serial1_tx_irq_i(src[14]),
        .serial1_rx_irq_i(src[15]), .gp_pin_zero_irq_i(src[16]),
        .timer_two_irq_i(src[19]), .twowire_irq_i(src[22]),
        .network_mgmt_irq_i(src[24]), .video_port_a_irq_i(src[25]),
        .video_port_b_irq_i(src[26]), .video_port_c_irq_i(src[27]),
        .audio_tx_irq_i(src[28]), .audio_rx_irq_i(src[29]),
        .core_irq_o(core_irq_o), .irq_o(irq_o));
    cis_core_model u_cis_core_model (.core_irq_i(core_irq_o),
        .top_line_o(top_line), .any_o(any_line));

    initial begin
        forever #2 ref_clk_i = ~ref_clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic conclude();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_i <= 1'b0;
    endtask

    // Data is taken in the cycle right after the strobe only
    task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge ref_clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Entered in the fifth reset cycle; the sixth edge ends reset
    task automatic t_reset_values();
        logic [31:0] d;
        check({16'h0000, core_irq_o}, 32'h0000_0001);
        @(posedge ref_clk_i);
        rst_i <= 1'b0;
        step(1);
        check({16'h0000, core_irq_o}, 32'h0000_0000);
        rd_reg(`CIS_OFF_SEL_HIGH, d);
        check(d, 32'h0820_2D43);
        step(1);
        check(rdata_o, 32'h0000_0000);
        rd_reg(`CIS_OFF_SEL_LOW, d);
        check(d, 32'h2507_18A4);
        rd_reg(`CIS_OFF_POLARITY, d);
        check(d, 32'h0000_0000);
        wr_reg(32'h019C_000C, 32'hFFFF_FFFF);
        rd_reg(32'h019C_000C, d);
        check(d, 32'h0000_0000);
    endtask

    task automatic t_defaults();
        for (int k = 0; k < 12; k++) begin
            @(posedge ref_clk_i);
            src <= 32'h1 << DFLT[k];
            step(2);
            check({16'h0000, core_irq_o}, 32'h1 << (k + 4));
        end
        @(posedge ref_clk_i);
        src <= 32'h0000_0000;
    endtask

    // Every legal code on every line
    task automatic t_all_codes();
        logic [31:0] w;
        logic [31:0] d;
        for (int c = 0; c < 32; c++) begin
            // Software never writes a reserved code
            if (c inside {17, 18, 20, 21, 23, 30, 31}) begin
                continue;
            end
            w = c | (c << 5) | (c << 10) | (c << 16) | (c << 21) | (c << 26);
            @(posedge ref_clk_i);
            src <= 32'h1 << c;
            wr_reg(`CIS_OFF_SEL_LOW, w);
            wr_reg(`CIS_OFF_SEL_HIGH, w);
            step(2);
            check({20'h0, core_irq_o[15:4]}, 32'h0000_0FFF);
            @(posedge ref_clk_i);
            src <= 32'h0000_0000;
            step(2);
            check({20'h0, core_irq_o[15:4]}, 32'h0000_0000);
        end
        // Code 16 in every field plus the two unused bits
        wr_reg(`CIS_OFF_SEL_LOW, 32'hC210_C210);
        rd_reg(`CIS_OFF_SEL_LOW, d);
        check(d, 32'h4210_4210);
        wr_reg(`CIS_OFF_SEL_LOW, `CIS_SEL_LOW_RST);
        wr_reg(`CIS_OFF_SEL_HIGH, `CIS_SEL_HIGH_RST);
    endtask

    task automatic t_polarity();
        logic [31:0] d;
        wr_reg(`CIS_OFF_POLARITY, 32'hFFFF_FFFF);
        rd_reg(`CIS_OFF_POLARITY, d);
        check(d, 32'h0000_000F);
        step(4);
        check({28'h0, core_irq_o[7:4]}, 32'h0000_000F);
        @(posedge ref_clk_i);
        ext_r <= 4'hF;
        step(4);
        check({28'h0, core_irq_o[7:4]}, 32'h0000_0000);
        wr_reg(`CIS_OFF_POLARITY, 32'h0000_0000);
        step(2);
        check({28'h0, core_irq_o[7:4]}, 32'h0000_000F);
        @(posedge ref_clk_i);
        ext_r <= 4'h0;
        step(4);
    endtask

    task automatic t_priority();
        @(posedge ref_clk_i);
        nmi_i <= 1'b1;
        src <= 32'h0000_0003;
        step(2);
        check({16'h0, core_irq_o}, 32'h0000_6002);
        check({28'h0, top_line}, 32'h0000_0001);
        check({31'h0, any_line}, 32'h0000_0001);
        @(posedge ref_clk_i);
        nmi_i <= 1'b0;
        step(2);
        check({28'h0, top_line}, 32'h0000_000D);
        @(posedge ref_clk_i);
        src <= 32'h0000_0000;
        step(2);
        check({31'h0, any_line}, 32'h0000_0000);
    endtask

    task automatic t_irq();
        logic [31:0] d;
        rd_reg(`CIS_OFF_IRQ_STATUS, d);
        wr_reg(`CIS_OFF_IRQ_MASK, 32'h0000_0001);
        src <= 32'h0000_0020;
        step(3);
        check({31'h0, irq_o}, 32'h0000_0000);
        @(posedge ref_clk_i);
        src <= 32'h0000_0030;
        step(3);
        check({31'h0, irq_o}, 32'h0000_0001);
        rd_reg(`CIS_OFF_IRQ_STATUS, d);
        check(d, 32'h0000_0003);
        check({31'h0, irq_o}, 32'h0000_0000);
        @(posedge ref_clk_i);
        src <= 32'h0000_0000;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge ref_clk_i);
        #1;
        t_reset_values();
        t_defaults();
        t_all_codes();
        t_polarity();
        t_priority();
        t_irq();
        conclude();
    end

    // Cuts a hung run short
    initial begin
        #200000;
        error_cnt++;
        conclude();
    end
endmodule
